// ---- hw/four_mode_serial_port.sv ----
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// How it works
// R1: mode_sel_hi and mode_sel_lo pick modes 0 to 3.
// R2: Mode 0 moves data on the receive pin, clock on transmit pin, eight bits LSB first.
// R3: Mode 0 shifts once every twelve core clocks.
// R4: Any serial_buffer write starts a transmission in every mode.
// R5: Mode 0 receives while receive_enable is 1 and rx_done_flag is 0.
// R6: Mode 1 frame is start zero, eight data bits LSB first, stop one.
// R7: Mode 1 sends a one as ninth bit; transmit_done_flag sets at stop bit.
// R8: Async modes start receiving on a falling receive line when enabled.
// R9: Mode 1 keeps a frame only if flag clear and filter passes stop bit.
// R10: Mode 2 frame is start, eight data bits, ninth bit, stop: eleven bits.
// R11: Mode 2 bit rate is core clock over 64, or 32 when doubled.
// R12: Mode 2 sends tx_ninth_bit, starts on next baud tick, flags at stop.
// R13: Mode 2 keeps data and ninth bit under the mode 1 acceptance terms.
// R14: Mode 3 is mode 2 with timer driven bit rate.
// R15: Timer 1 bit rate is two to baud_doubler over 32 times overflow rate.
// R16: Timer 1 autoreload overflows every twelve clocks times 256 minus reload.
// R17: Software keeps the timer 1 interrupt off while it sets bit rate.
// R18: Timer 2 selects give each direction its own rate source.
// R19: Sixteen sample ticks make one bit time.
// R20: Timer 2 steps every two clocks and reloads from its 16-bit reload.
// R21: Buffer writes load transmit side, reads return separate receive buffer.
// R22: Receiver holds one byte while the next is shifted in.
// R23: Software clears transmit_done_flag; hardware never does.
// R24: Modes 2 and 3 with filter drop frames whose ninth bit is zero.
// R25: Receiver samples sixteen times per bit and drops starts high at mid-bit.
module four_mode_serial_port #(
  parameter int ADDR_W = 8
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic RXD_I,
  output logic RXD_O,
  output logic RXD_OE_N_O,
  output logic TXD_O
);
  import serial_port_pkg::*;

  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W must hold the 8-bit register addresses");
  end

  typedef struct packed {
    logic mode_sel_hi;
    logic mode_sel_lo;
    logic multiproc_filter;
    logic receive_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic transmit_done_flag;
    logic rx_done_flag;
    logic baud_doubler;
    logic t2_tx_baud_select;
    logic t2_rx_baud_select;
    logic [7:0] t1_reload;
    logic [15:0] t2_reload;
    logic [7:0] rx_buf;
    logic [7:0] rdata;
    logic rxd_meta;
    logic rxd_sync;
    logic rxd_prev;
    logic [3:0] pre12;
    logic [7:0] t1_cnt;
    logic t1_half;
    logic t2_pre;
    logic [15:0] t2_cnt;
    logic [1:0] m2_pre;
    logic tx_pending;
    logic tx_busy;
    logic [10:0] tx_shift;
    logic [3:0] tx_left;
    logic [3:0] tx_phase;
    logic txd;
    logic rxd_out;
    logic rxd_oe_n;
    logic m0_busy;
    logic m0_run;
    logic m0_rx;
    logic [3:0] m0_bits;
    logic [7:0] m0_shift;
    rx_state_t rx_state;
    logic [3:0] rx_phase;
    logic [3:0] rx_left;
    logic [8:0] rx_shift;
  } state_t;

  localparam state_t S_RESET = '{
    txd: 1'b1, rxd_out: 1'b1, rxd_oe_n: 1'b1,
    rxd_meta: 1'b1, rxd_sync: 1'b1, rxd_prev: 1'b1,
    rx_state: RX_IDLE, default: '0};

  function automatic mode_t decode_mode(input logic hi, input logic lo);
    return mode_t'({hi, lo});
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] r);
    return a == ADDR_W'(r);
  endfunction

  state_t s;
  state_t n;
  mode_t mode;
  logic wr_sc;
  logic wr_sb;
  logic t1_ovf;
  logic t1_tick;
  logic t2_ovf;
  logic m2_tick;
  logic tx_tick;
  logic rx_tick;
  logic rx_frame_end;
  logic rx_ninth_now;
  logic [7:0] rx_data_now;

  assign mode = decode_mode(s.mode_sel_hi, s.mode_sel_lo); // [R1]
  assign wr_sc = WR_I && hit(ADDR_I, SERIAL_CONTROL_ADDR);
  assign wr_sb = WR_I && hit(ADDR_I, SERIAL_BUFFER_ADDR);

  // Timer 1 runs as an 8-bit autoreload timer stepped once per machine cycle.
  assign t1_ovf = (s.pre12 == MCYCLE_LAST) && (s.t1_cnt == T1_TOP); // [R16]
  // Without doubling every second overflow counts, giving the divide by 32.
  assign t1_tick = t1_ovf && (s.baud_doubler || s.t1_half); // [R15]
  assign t2_ovf = s.t2_pre && (s.t2_cnt == T2_TOP); // [R20]
  assign m2_tick = s.baud_doubler ? s.m2_pre[0] : (&s.m2_pre); // [R11]
  // Each direction picks its own source; sixteen ticks form one bit.
  assign tx_tick = (mode == MODE_UART9_FIX) ? m2_tick :
                   (s.t2_tx_baud_select ? t2_ovf : t1_tick); // [R18] [R14]
  assign rx_tick = (mode == MODE_UART9_FIX) ? m2_tick :
                   (s.t2_rx_baud_select ? t2_ovf : t1_tick); // [R18] [R14]
  assign rx_frame_end = (s.rx_state == RX_STOP) && rx_tick && (s.rx_phase == OVS_LAST);
  // Mode 1 keeps the stop bit as ninth bit; the 9-bit modes keep bit nine.
  assign rx_ninth_now = (mode == MODE_UART8) ? s.rxd_sync : s.rx_shift[8];
  assign rx_data_now = (mode == MODE_UART8) ? s.rx_shift[8:1] : s.rx_shift[7:0];

  always_comb begin
    n = s;
    n.rxd_meta = RXD_I;
    n.rxd_sync = s.rxd_meta;
    n.rxd_prev = s.rxd_sync;

    n.rdata = '0;
    if (RD_I) begin
      if (hit(ADDR_I, SERIAL_CONTROL_ADDR)) begin
        n.rdata = {s.mode_sel_hi, s.mode_sel_lo, s.multiproc_filter, s.receive_enable,
                   s.tx_ninth_bit, s.rx_ninth_bit, s.transmit_done_flag, s.rx_done_flag};
      end else if (hit(ADDR_I, SERIAL_BUFFER_ADDR)) begin
        n.rdata = s.rx_buf; // [R21]
      end else if (hit(ADDR_I, BAUD_CONTROL_ADDR)) begin
        n.rdata = {5'h00, s.t2_rx_baud_select, s.t2_tx_baud_select, s.baud_doubler};
      end else if (hit(ADDR_I, T2_RELOAD_LOW_ADDR)) begin
        n.rdata = s.t2_reload[7:0];
      end else if (hit(ADDR_I, T2_RELOAD_HIGH_ADDR)) begin
        n.rdata = s.t2_reload[15:8];
      end else if (hit(ADDR_I, T1_RELOAD_ADDR)) begin
        n.rdata = s.t1_reload;
      end
    end

    if (wr_sc) begin
      {n.mode_sel_hi, n.mode_sel_lo, n.multiproc_filter, n.receive_enable,
       n.tx_ninth_bit, n.rx_ninth_bit, n.transmit_done_flag, n.rx_done_flag} = WDATA_I;
    end
    if (WR_I && hit(ADDR_I, BAUD_CONTROL_ADDR)) begin
      n.baud_doubler = WDATA_I[BC_DOUBLER];
      n.t2_tx_baud_select = WDATA_I[BC_T2_TX];
      n.t2_rx_baud_select = WDATA_I[BC_T2_RX];
    end
    if (WR_I && hit(ADDR_I, T2_RELOAD_LOW_ADDR)) begin
      n.t2_reload[7:0] = WDATA_I;
    end
    if (WR_I && hit(ADDR_I, T2_RELOAD_HIGH_ADDR)) begin
      n.t2_reload[15:8] = WDATA_I;
    end
    if (WR_I && hit(ADDR_I, T1_RELOAD_ADDR)) begin
      n.t1_reload = WDATA_I;
    end

    n.pre12 = (s.pre12 == MCYCLE_LAST) ? '0 : s.pre12 + 4'h1; // [R3]
    n.m2_pre = s.m2_pre + 2'h1;
    if (s.pre12 == MCYCLE_LAST) begin
      n.t1_cnt = t1_ovf ? s.t1_reload : s.t1_cnt + 8'h01; // [R16]
    end
    if (t1_ovf) begin
      n.t1_half = !s.t1_half;
    end
    // Timer 2 only counts while some direction has it as rate source.
    if (s.t2_tx_baud_select || s.t2_rx_baud_select) begin
      n.t2_pre = !s.t2_pre;
      if (s.t2_pre) begin
        n.t2_cnt = t2_ovf ? s.t2_reload : s.t2_cnt + 16'h0001; // [R20]
      end
    end else begin
      // The count itself cannot be written, so an idle timer 2 follows its reload value.
      // Otherwise the first bit after a select could wait a whole 16-bit pass.
      n.t2_pre = 1'b0;
      n.t2_cnt = s.t2_reload; // [R20]
    end

    // Shift register mode: clock low for six core clocks, high for six.
    if (s.m0_busy) begin
      if (!s.m0_run) begin
        if (s.pre12 == MCYCLE_LAST) begin
          n.m0_run = 1'b1;
          n.txd = 1'b0; // [R2]
          n.rxd_out = s.m0_shift[0];
        end
      end else if (s.pre12 == MCYCLE_LAST) begin
        n.txd = 1'b0;
        n.rxd_out = s.m0_shift[0]; // [R2]
      end else if (s.pre12 == M0_RISE_AT) begin
        n.txd = 1'b1;
        n.m0_bits = s.m0_bits + 4'h1;
        n.m0_shift = s.m0_rx ? {s.rxd_sync, s.m0_shift[7:1]} : {1'b1, s.m0_shift[7:1]};
        if (s.m0_bits == M0_LAST_BIT) begin // [R2]
          n.m0_busy = 1'b0;
          n.m0_run = 1'b0;
          if (s.m0_rx) begin
            n.rx_buf = {s.rxd_sync, s.m0_shift[7:1]};
            n.rx_done_flag = 1'b1;
          end else begin
            n.transmit_done_flag = 1'b1;
          end
        end
      end
    end else if (mode == MODE_SHIFT && s.receive_enable && !s.rx_done_flag) begin
      n.m0_busy = 1'b1; // [R5]
      n.m0_rx = 1'b1;
      n.m0_bits = '0;
    end

    // A buffer write restarts the transmitter whatever it was doing.
    if (wr_sb) begin
      if (mode == MODE_SHIFT) begin
        n.m0_busy = 1'b1; // [R4]
        n.m0_run = 1'b0;
        n.m0_rx = 1'b0;
        n.m0_bits = '0;
        n.m0_shift = WDATA_I;
        n.txd = 1'b1;
      end else begin
        n.tx_pending = 1'b1; // [R4]
        n.tx_busy = 1'b0;
        n.txd = 1'b1;
        if (mode == MODE_UART8) begin
          n.tx_shift = {2'b11, WDATA_I, 1'b0}; // [R7] [R6]
          n.tx_left = TX_LEFT_8;
        end else begin
          n.tx_shift = {1'b1, s.tx_ninth_bit, WDATA_I, 1'b0}; // [R10] [R12]
          n.tx_left = TX_LEFT_9;
        end
      end
    end else if (s.tx_pending && tx_tick) begin
      n.tx_pending = 1'b0; // [R12]
      n.tx_busy = 1'b1;
      n.tx_phase = '0;
      n.txd = s.tx_shift[0];
    end else if (s.tx_busy && tx_tick) begin
      n.tx_phase = s.tx_phase + 4'h1;
      if (s.tx_phase == OVS_LAST) begin // [R19]
        if (s.tx_left == '0) begin
          n.tx_busy = 1'b0;
        end else begin
          n.tx_shift = {1'b1, s.tx_shift[10:1]};
          n.txd = s.tx_shift[1];
          n.tx_left = s.tx_left - 4'h1;
          if (s.tx_left == 4'h1) begin
            n.transmit_done_flag = 1'b1; // [R7] [R12]
          end
        end
      end
    end

    unique case (s.rx_state)
      RX_IDLE: begin
        if (mode != MODE_SHIFT && s.receive_enable && s.rxd_prev && !s.rxd_sync) begin
          n.rx_state = RX_START; // [R8]
          n.rx_phase = '0;
        end
      end
      RX_START: begin
        if (rx_tick) begin
          n.rx_phase = s.rx_phase + 4'h1;
          if (s.rx_phase == OVS_MID) begin
            n.rx_phase = '0;
            // A glitch that is gone by mid-bit is not a start bit.
            n.rx_state = s.rxd_sync ? RX_IDLE : RX_DATA; // [R25]
            n.rx_left = (mode == MODE_UART8) ? RX_BITS_8 : RX_BITS_9;
          end
        end
      end
      RX_DATA: begin
        if (rx_tick) begin
          n.rx_phase = s.rx_phase + 4'h1;
          if (s.rx_phase == OVS_LAST) begin // [R19] [R25]
            n.rx_shift = {s.rxd_sync, s.rx_shift[8:1]}; // [R8]
            n.rx_left = s.rx_left - 4'h1;
            if (s.rx_left == 4'h1) begin
              n.rx_state = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (rx_tick) begin
          n.rx_phase = s.rx_phase + 4'h1;
          if (rx_frame_end) begin
            n.rx_state = RX_IDLE;
            // The shifter is the second buffer; rx_buf changes only here and at the end of a mode 0 receive.
            if (!s.rx_done_flag && (!s.multiproc_filter || rx_ninth_now)) begin
              n.rx_buf = rx_data_now; // [R9] [R13] [R22] [R24]
              n.rx_ninth_bit = rx_ninth_now;
              n.rx_done_flag = 1'b1;
            end
          end
        end
      end
    endcase

    n.rxd_oe_n = !(n.m0_run && !n.m0_rx); // [R2]
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      s <= S_RESET;
    end else if (CE_I) begin
      s <= n;
    end
  end

  assign RDATA_O = s.rdata;
  assign TXD_O = s.txd;
  assign RXD_O = s.rxd_out;
  assign RXD_OE_N_O = s.rxd_oe_n;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence m0_low_s;
    s.m0_run && (s.pre12 == M0_PROBE_LOW);
  endsequence
  sequence m0_high_s;
    s.m0_run && (s.pre12 == M0_PROBE_HIGH);
  endsequence
  sequence frame_kept_s;
    rx_frame_end && CE_I && !s.rx_done_flag && !s.multiproc_filter;
  endsequence

  a_shift_clk_low: assert property (m0_low_s |-> !TXD_O) // [R3]
    else $error("shift clock not low in first half of machine cycle");
  a_shift_clk_high: assert property (m0_high_s |-> TXD_O) // [R3]
    else $error("shift clock not high in second half of machine cycle");
  a_m0_pin_drive: assert property (
    (mode != MODE_SHIFT) && !s.m0_busy |-> RXD_OE_N_O) // [R2]
    else $error("receive pin driven outside shift mode");
  a_write_arms_tx: assert property (
    CE_I && wr_sb && (mode != MODE_SHIFT) |=> s.tx_pending && !s.tx_busy) // [R4]
    else $error("buffer write did not arm the transmitter");
  a_tx_start_bit: assert property ($rose(s.tx_busy) |-> !TXD_O && (s.tx_phase == '0)) // [R6]
    else $error("frame did not open with a zero start bit");
  a_tx_flag_stop: assert property (
    $rose(s.transmit_done_flag) && !$past(wr_sc) |-> TXD_O) // [R7] [R12]
    else $error("transmit flag rose while line not high");
  a_tx_flag_hold: assert property (
    s.transmit_done_flag && !wr_sc |=> s.transmit_done_flag) // [R23]
    else $error("hardware cleared transmit flag");
  a_rx_kept: assert property (
    frame_kept_s |=> s.rx_done_flag && (s.rx_buf == $past(rx_data_now))) // [R9] [R13]
    else $error("accepted frame not latched");
  a_rx_full_drop: assert property (
    rx_frame_end && s.rx_done_flag |=> $stable(s.rx_buf)) // [R9]
    else $error("frame overwrote unread buffer");
  a_mp_filter_drop: assert property (
    rx_frame_end && s.multiproc_filter && !rx_ninth_now && !s.rx_done_flag
    |=> $stable(s.rx_buf) && !s.rx_done_flag) // [R24]
    else $error("filtered frame raised receive flag");
  a_false_start: assert property (
    CE_I && (s.rx_state == RX_START) && rx_tick && (s.rx_phase == OVS_MID) && s.rxd_sync
    |=> s.rx_state == RX_IDLE) // [R25]
    else $error("high line at mid start bit not abandoned");
  a_m2_fast_tick: assert property (
    CE_I && s.baud_doubler && m2_tick |=> !m2_tick) // [R11]
    else $error("mode 2 sample tick too fast");
endmodule // four_mode_serial_port

// ---- shared/serial_port_pkg.sv ----
package serial_port_pkg;
  // Register addresses on the plain register port.
  localparam logic [7:0] SERIAL_CONTROL_ADDR = 8'h98;
  localparam logic [7:0] SERIAL_BUFFER_ADDR = 8'h99;
  localparam logic [7:0] BAUD_CONTROL_ADDR = 8'h9a;
  localparam logic [7:0] T2_RELOAD_LOW_ADDR = 8'h9b;
  localparam logic [7:0] T2_RELOAD_HIGH_ADDR = 8'h9c;
  localparam logic [7:0] T1_RELOAD_ADDR = 8'h9d;
  localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
  // Bit positions of baud control.
  localparam int BC_DOUBLER = 0;
  localparam int BC_T2_TX = 1;
  localparam int BC_T2_RX = 2;
  // Machine cycle of twelve core clocks and the mode 0 shift clock phases.
  localparam logic [3:0] MCYCLE_LAST = 4'hb;
  localparam logic [3:0] M0_RISE_AT = 4'h5;
  localparam logic [3:0] M0_PROBE_LOW = 4'h3;
  localparam logic [3:0] M0_PROBE_HIGH = 4'h9;
  localparam logic [3:0] M0_LAST_BIT = 4'h7;
  // Sixteen sample ticks make one bit time.
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] TX_LEFT_8 = 4'h9;
  localparam logic [3:0] TX_LEFT_9 = 4'ha;
  localparam logic [3:0] RX_BITS_8 = 4'h8;
  localparam logic [3:0] RX_BITS_9 = 4'h9;
  localparam logic [7:0] T1_TOP = 8'hff;
  localparam logic [15:0] T2_TOP = 16'hffff;
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_UART8 = 2'b01,
    MODE_UART9_FIX = 2'b10,
    MODE_UART9_VAR = 2'b11
  } mode_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } rx_state_t;
endpackage

// ---- tb/remote_serial_end.sv ----
`timescale 1ns/1ps
// Far end of the link: it watches the device pins and drives the receive line.
module remote_serial_end (
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic rxd_data_i,
  output logic line_o
);
  initial line_o = 1'b1;

  // Frames leave least significant bit first, bclk clocks per bit.
  task automatic send_frame(input logic [10:0] f, input int n, input int bclk);
    @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      line_o <= f[i];
      repeat (bclk) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask

  // Samples each bit in its middle, starting with the start bit.
  task automatic catch_frame(input int n, input int bclk, output logic [10:0] f);
    f = '0;
    @(negedge txd_i);
    repeat (bclk / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      f[i] = txd_i;
      if (i < n - 1) repeat (bclk) @(posedge clk_i);
    end
  endtask

  // Shift data is taken on each rising shift clock; period is rise to rise.
  task automatic catch_shift(output logic [7:0] d, output time period);
    time t0;
    t0 = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge txd_i);
      d[i] = rxd_data_i;
      period = $time - t0;
      t0 = $time;
    end
  endtask

  // Data changes on the falling shift clock so it is settled at the rise.
  task automatic serve_shift(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd_i);
      line_o <= d[i];
    end
    @(posedge txd_i);
    repeat (4) @(posedge clk_i);
    line_o <= 1'b1;
  endtask
endmodule // remote_serial_end

// ---- tb/four_mode_serial_port_tb.sv ----
`timescale 1ns/1ps
module four_mode_serial_port_tb;
  import serial_port_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rxd_out;
  logic rxd_oe_n;
  logic txd;
  logic line;
  logic rxd_pin;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;
  // The receive pin carries the device's data only while it drives the pin.
  assign rxd_pin = rxd_oe_n ? line : rxd_out;

  four_mode_serial_port uut (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RXD_I(rxd_pin),
    .RXD_O(rxd_out), .RXD_OE_N_O(rxd_oe_n), .TXD_O(txd));
  remote_serial_end partner (.clk_i(clk), .txd_i(txd), .rxd_data_i(rxd_out), .line_o(line));

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // The whole run needs about 14000 cycles; a hang is cut at 40000.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask

  task automatic push(input logic [8:0] d9, input int bclk);
    partner.send_frame({1'b1, d9, 1'b0}, 11, bclk);
    repeat (16) @(posedge clk);
  endtask

  task automatic check_reset;
    expect_reg(SERIAL_CONTROL_ADDR, SERIAL_CONTROL_RESET);
    expect_reg(8'h9e, 8'h00);
    chk(txd, 1'b1);
    // A write made while the clock enable is low must leave no trace.
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(T2_RELOAD_LOW_ADDR, 8'h5a);
    ce <= 1'b1;
    expect_reg(T2_RELOAD_LOW_ADDR, 8'h00);
  endtask

  task automatic mode0_tx;
    logic [7:0] d;
    time p;
    wr_reg(SERIAL_CONTROL_ADDR, 8'h00);
    fork
      partner.catch_shift(d, p);
      wr_reg(SERIAL_BUFFER_ADDR, 8'hc6);
    join
    chk(d, 8'hc6);
    chk(p[15:0], 16'd60);
    repeat (20) @(posedge clk);
    expect_reg(SERIAL_CONTROL_ADDR, 8'h02);
    chk(rxd_oe_n, 1'b1);
  endtask

  task automatic mode0_rx;
    fork
      partner.serve_shift(8'h6b);
      wr_reg(SERIAL_CONTROL_ADDR, 8'h10);
    join
    repeat (20) @(posedge clk);
    expect_reg(SERIAL_BUFFER_ADDR, 8'h6b);
    expect_reg(SERIAL_CONTROL_ADDR, 8'h11);
    wr_reg(SERIAL_CONTROL_ADDR, 8'h00);
  endtask

  task automatic mode2_tx;
    logic [10:0] f;
    // Without doubling one bit lasts 64 clocks.
    wr_reg(SERIAL_CONTROL_ADDR, 8'h80);
    fork
      partner.catch_frame(11, 64, f);
      wr_reg(SERIAL_BUFFER_ADDR, 8'h5c);
    join
    chk(f, {1'b1, 1'b0, 8'h5c, 1'b0});
    expect_reg(SERIAL_CONTROL_ADDR, 8'h82);
    repeat (40) @(posedge clk);
    wr_reg(BAUD_CONTROL_ADDR, 8'h01);
    wr_reg(SERIAL_CONTROL_ADDR, 8'h88);
    fork
      partner.catch_frame(11, 32, f);
      wr_reg(SERIAL_BUFFER_ADDR, 8'ha5);
    join
    chk(f, {1'b1, 1'b1, 8'ha5, 1'b0});
    expect_reg(SERIAL_CONTROL_ADDR, 8'h8a);
  endtask

  task automatic mode2_rx;
    wr_reg(SERIAL_CONTROL_ADDR, 8'h90);
    push(9'h13c, 32);
    expect_reg(SERIAL_BUFFER_ADDR, 8'h3c);
    expect_reg(SERIAL_CONTROL_ADDR, 8'h95);
    push(9'h0c3, 32);
    expect_reg(SERIAL_BUFFER_ADDR, 8'h3c);
    // Software clears the flags itself by rewriting the control byte.
    wr_reg(SERIAL_CONTROL_ADDR, 8'hb0);
    push(9'h055, 32);
    expect_reg(SERIAL_CONTROL_ADDR, 8'hb0);
    push(9'h181, 32);
    expect_reg(SERIAL_BUFFER_ADDR, 8'h81);
    expect_reg(SERIAL_CONTROL_ADDR, 8'hb5);
  endtask

  task automatic mode1_tx;
    logic [10:0] f;
    // Timer 1 overflows every 12 clocks with a reload of all ones.
    wr_reg(T1_RELOAD_ADDR, 8'hff);
    wr_reg(BAUD_CONTROL_ADDR, 8'h01);
    wr_reg(SERIAL_CONTROL_ADDR, 8'h40);
    fork
      partner.catch_frame(10, 192, f);
      wr_reg(SERIAL_BUFFER_ADDR, 8'h39);
    join
    chk(f[9:0], {1'b1, 8'h39, 1'b0});
    expect_reg(SERIAL_CONTROL_ADDR, 8'h42);
  endtask

  task automatic mode1_rx;
    // Without doubling every second timer 1 overflow counts, so one bit lasts 384 clocks.
    wr_reg(BAUD_CONTROL_ADDR, 8'h00);
    wr_reg(SERIAL_CONTROL_ADDR, 8'h70);
    partner.send_frame({2'b00, 8'h5e, 1'b0}, 10, 384);
    repeat (16) @(posedge clk);
    expect_reg(SERIAL_CONTROL_ADDR, 8'h70);
    partner.send_frame({2'b11, 8'h5e, 1'b0}, 10, 384);
    repeat (16) @(posedge clk);
    expect_reg(SERIAL_BUFFER_ADDR, 8'h5e);
    expect_reg(SERIAL_CONTROL_ADDR, 8'h75);
  endtask

  task automatic mode3_rx;
    logic [10:0] f;
    // Timer 2 overflows every 4 clocks, so one bit lasts 64 clocks.
    wr_reg(T2_RELOAD_LOW_ADDR, 8'hfe);
    wr_reg(T2_RELOAD_HIGH_ADDR, 8'hff);
    wr_reg(BAUD_CONTROL_ADDR, 8'h04);
    wr_reg(SERIAL_CONTROL_ADDR, 8'hd0);
    partner.send_frame(11'h000, 1, 8);
    repeat (80) @(posedge clk);
    expect_reg(SERIAL_CONTROL_ADDR, 8'hd0);
    push(9'h19a, 64);
    expect_reg(SERIAL_BUFFER_ADDR, 8'h9a);
    expect_reg(SERIAL_CONTROL_ADDR, 8'hd5);
    // Both directions now take timer 2, so the transmitter also uses 64 clocks a bit.
    wr_reg(BAUD_CONTROL_ADDR, 8'h06);
    wr_reg(SERIAL_CONTROL_ADDR, 8'hc8);
    fork
      partner.catch_frame(11, 64, f);
      wr_reg(SERIAL_BUFFER_ADDR, 8'h3e);
    join
    chk(f, {1'b1, 1'b1, 8'h3e, 1'b0});
    expect_reg(SERIAL_CONTROL_ADDR, 8'hca);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    check_reset();
    mode0_tx();
    mode0_rx();
    mode2_tx();
    mode2_rx();
    mode1_tx();
    mode1_rx();
    mode3_rx();
    end_of_test();
  end
endmodule // four_mode_serial_port_tb
